// [verilog/qsmpi_defines.vh]
// Purpose: shared constants of the serial memory pin front end
// Assumes: included by the pin front end and its buffer
// Notes: lane numbers follow the dual-purpose pin order
`ifndef QSMPI_DEFINES_VH
`define QSMPI_DEFINES_VH

`define QSMPI_BYTE_W 8
`define QSMPI_LANES 4
`define QSMPI_LANE_SI 0
`define QSMPI_LANE_SO 1
`define QSMPI_LANE_WP 2
`define QSMPI_LANE_HOLD 3
`define QSMPI_CNT_W 3
`define QSMPI_SINGLE_LAST 3'h7
`define QSMPI_QUAD_LAST 3'h1
`define QSMPI_CNT_ZERO 3'h0
`define QSMPI_CNT_ONE 3'h1
`define QSMPI_SCK_MAX_MHZ 104
`define QSMPI_REF_MHZ 25
`define QSMPI_IDLE_FILL 8'hFF

`endif

// [verilog/qsmpi_buf2.v]
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: one clock, asynchronous active-high reset
// Notes: head word and valid come straight from flip-flops
`timescale 1ns/1ps
`include "qsmpi_defines.vh"

module qsmpi_buf2
(
    input wire ref_clk,
    input wire sys_rst,
    input wire [`QSMPI_BYTE_W-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output reg [`QSMPI_BYTE_W-1:0] out_data,
    output reg out_valid,
    input wire out_ready
);

reg [`QSMPI_BYTE_W-1:0] tail_r;
reg tail_v_r;
wire push;
wire pop;

assign in_ready = ~tail_v_r;
assign push = in_valid & ~tail_v_r;
assign pop = out_valid & out_ready;

always @(posedge ref_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        out_data <= {`QSMPI_BYTE_W{1'b0}};
        out_valid <= 1'b0;
        tail_r <= {`QSMPI_BYTE_W{1'b0}};
        tail_v_r <= 1'b0;
    end
    else if (pop)
    begin
        if (tail_v_r)
        begin
            out_data <= tail_r;
            out_valid <= 1'b1;
            tail_v_r <= 1'b0;
        end
        else
        begin
            if (push)
                out_data <= in_data;
            out_valid <= push;
        end
    end
    else if (push)
    begin
        if (!out_valid)
        begin
            out_data <= in_data;
            out_valid <= 1'b1;
        end
        else
        begin
            tail_r <= in_data;
            tail_v_r <= 1'b1;
        end
    end
end

endmodule

// [verilog/qsmpi_pins.v]
// Purpose: pin-level front end of a serial memory, single and quad lanes
// Assumes: serial clock is far slower than ref_clk; all pins pass two flip-flops
// Notes: lane 0..3 share the input, output, protect and pause pins
`timescale 1ns/1ps
`include "qsmpi_defines.vh"

// Behaviour
// - Respond only while chip select low; standby otherwise
// - Single lane: drive output only during reads
// - Single lane: output changes on falling clock edges
// - Single lane: sample input on rising edges only
// - Quad: four bidirectional lanes, rise in, fall out
// - Single lane: protect low refuses status writes
// - Accept clock idling low or idling high
// - Fully static; clock may stop anytime
// - Serial clock at most 104 MHz; here pin sampling needs each sck phase to span three ref cycles
// - Single lane: pause low suspends, not aborts
// - Single lane: pause low ignores chip select and clock
module qsmpi_pins
(
    input wire ref_clk,
    input wire sys_rst,
    input wire cs_n_pin,
    input wire sck_pin,
    input wire [`QSMPI_LANES-1:0] io_i,
    output reg [`QSMPI_LANES-1:0] io_o,
    output reg [`QSMPI_LANES-1:0] io_oe,
    input wire quad_mode,
    input wire read_active,
    output wire [`QSMPI_BYTE_W-1:0] rx_data,
    output wire rx_valid,
    input wire rx_ready,
    input wire [`QSMPI_BYTE_W-1:0] tx_data,
    input wire tx_valid,
    output reg tx_ready,
    output reg selected_r,
    output reg standby_r,
    output reg paused_r,
    output reg sr_write_block_r,
    output reg rx_overrun_r,
    output reg tx_underrun_r
);

reg [`QSMPI_LANES+1:0] sync1_r;
reg [`QSMPI_LANES+1:0] sync2_r;
reg sck_d_r;
reg [`QSMPI_BYTE_W-1:0] rx_sh_r;
reg [`QSMPI_CNT_W-1:0] rx_cnt_r;
reg [`QSMPI_BYTE_W-1:0] rx_word_r;
reg rx_push_r;
reg [`QSMPI_BYTE_W-1:0] tx_sh_r;
reg [`QSMPI_CNT_W-1:0] tx_cnt_r;
reg [`QSMPI_BYTE_W-1:0] tx_hold_r;
reg tx_full_r;
reg tx_full_nxt;
reg [`QSMPI_BYTE_W-1:0] tx_word;
reg tx_load;

wire cs_n_s;
wire sck_s;
wire [`QSMPI_LANES-1:0] io_s;
wire pause_s;
wire sck_rise;
wire sck_fall;
wire act;
wire rx_in_ready;
wire take;

// Both stages of every pin synchroniser; only the second is read by logic
always @(posedge ref_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        sync1_r <= {(`QSMPI_LANES+2){1'b1}};
        sync2_r <= {(`QSMPI_LANES+2){1'b1}};
    end
    else
    begin
        // Pin sampling caps sck: each phase must span three ref cycles, far below the pin limit
        sync1_r <= {cs_n_pin, sck_pin, io_i};
        sync2_r <= sync1_r;
    end
end

assign cs_n_s = sync2_r[`QSMPI_LANES+1];
assign sck_s = sync2_r[`QSMPI_LANES];
assign io_s = sync2_r[`QSMPI_LANES-1:0];
// In quad mode the pause pin is data lane 3 and never pauses
assign pause_s = ~quad_mode & ~io_s[`QSMPI_LANE_HOLD];
// Edges only count while selected and not paused; any idle level works
assign sck_rise = sck_s & ~sck_d_r & act & ~pause_s;
assign sck_fall = ~sck_s & sck_d_r & act & ~pause_s;
assign act = selected_r;
assign take = tx_valid & tx_ready;

// Select follows the pin except while paused; all progress is held in flops
always @(posedge ref_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        sck_d_r <= 1'b1;
        selected_r <= 1'b0;
        standby_r <= 1'b1;
        paused_r <= 1'b0;
        sr_write_block_r <= 1'b0;
    end
    else
    begin
        // Edge history tracks the pin even when paused, so no stale edge fires on resume
        sck_d_r <= sck_s;
        if (!pause_s)
        begin
            selected_r <= ~cs_n_s;
            standby_r <= cs_n_s;
        end
        paused_r <= pause_s & selected_r;
        sr_write_block_r <= ~quad_mode & ~io_s[`QSMPI_LANE_WP];
    end
end

// Receive: one bit or one nibble per rising edge, MSB first
always @(posedge ref_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        rx_sh_r <= {`QSMPI_BYTE_W{1'b0}};
        rx_cnt_r <= `QSMPI_CNT_ZERO;
        rx_word_r <= {`QSMPI_BYTE_W{1'b0}};
        rx_push_r <= 1'b0;
        rx_overrun_r <= 1'b0;
    end
    else
    begin
        if (rx_push_r && rx_in_ready)
            rx_push_r <= 1'b0;
        if (!act && !pause_s)
            rx_cnt_r <= `QSMPI_CNT_ZERO;
        else if (sck_rise && !(quad_mode && read_active))
        begin
            if (!quad_mode)
            begin
                rx_sh_r <= {rx_sh_r[`QSMPI_BYTE_W-2:0], io_s[`QSMPI_LANE_SI]};
                rx_cnt_r <= rx_cnt_r + `QSMPI_CNT_ONE;
                if (rx_cnt_r == `QSMPI_SINGLE_LAST)
                begin
                    rx_word_r <= {rx_sh_r[`QSMPI_BYTE_W-2:0], io_s[`QSMPI_LANE_SI]};
                    rx_push_r <= 1'b1;
                    rx_overrun_r <= rx_overrun_r | (rx_push_r & ~rx_in_ready);
                end
            end
            else
            begin
                rx_sh_r <= {rx_sh_r[`QSMPI_LANES-1:0], io_s};
                if (rx_cnt_r == `QSMPI_QUAD_LAST)
                begin
                    rx_cnt_r <= `QSMPI_CNT_ZERO;
                    rx_word_r <= {rx_sh_r[`QSMPI_LANES-1:0], io_s};
                    rx_push_r <= 1'b1;
                    rx_overrun_r <= rx_overrun_r | (rx_push_r & ~rx_in_ready);
                end
                else
                    rx_cnt_r <= rx_cnt_r + `QSMPI_CNT_ONE;
            end
        end
    end
end

// Buffer absorbs a receiver stall of up to two words; the link itself cannot stall
qsmpi_buf2 u_rx_buf
(
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .in_data(rx_word_r),
    .in_valid(rx_push_r),
    .in_ready(rx_in_ready),
    .out_data(rx_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready)
);

// Transmit byte selection: prefetched byte, else fill with ones
always @*
begin
    tx_load = sck_fall & read_active & (tx_cnt_r == `QSMPI_CNT_ZERO);
    tx_word = tx_full_r ? tx_hold_r : `QSMPI_IDLE_FILL;
    tx_full_nxt = tx_full_r;
    if (tx_load)
        tx_full_nxt = 1'b0;
    if (take)
        tx_full_nxt = 1'b1;
end

always @(posedge ref_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        tx_hold_r <= {`QSMPI_BYTE_W{1'b0}};
        tx_full_r <= 1'b0;
        tx_ready <= 1'b0;
        tx_sh_r <= {`QSMPI_BYTE_W{1'b0}};
        tx_cnt_r <= `QSMPI_CNT_ZERO;
        tx_underrun_r <= 1'b0;
        io_o <= {`QSMPI_LANES{1'b0}};
        io_oe <= {`QSMPI_LANES{1'b0}};
    end
    else
    begin
        if (take)
            tx_hold_r <= tx_data;
        tx_full_r <= tx_full_nxt;
        tx_ready <= ~tx_full_nxt & ~take;
        if (!act && !pause_s)
            tx_cnt_r <= `QSMPI_CNT_ZERO;
        else if (sck_fall && read_active)
        begin
            // Output changes only here, on a falling serial clock edge
            if (tx_load)
            begin
                tx_underrun_r <= tx_underrun_r | ~tx_full_r;
                if (!quad_mode)
                begin
                    io_o[`QSMPI_LANE_SO] <= tx_word[`QSMPI_BYTE_W-1];
                    tx_sh_r <= {tx_word[`QSMPI_BYTE_W-2:0], 1'b0};
                    tx_cnt_r <= `QSMPI_SINGLE_LAST;
                end
                else
                begin
                    io_o <= tx_word[`QSMPI_BYTE_W-1:`QSMPI_LANES];
                    tx_sh_r <= {tx_word[`QSMPI_LANES-1:0], {`QSMPI_LANES{1'b0}}};
                    tx_cnt_r <= `QSMPI_QUAD_LAST;
                end
            end
            else
            begin
                if (!quad_mode)
                begin
                    io_o[`QSMPI_LANE_SO] <= tx_sh_r[`QSMPI_BYTE_W-1];
                    tx_sh_r <= {tx_sh_r[`QSMPI_BYTE_W-2:0], 1'b0};
                end
                else
                begin
                    io_o <= tx_sh_r[`QSMPI_BYTE_W-1:`QSMPI_LANES];
                    tx_sh_r <= {tx_sh_r[`QSMPI_LANES-1:0], {`QSMPI_LANES{1'b0}}};
                end
                tx_cnt_r <= tx_cnt_r - `QSMPI_CNT_ONE;
            end
        end
        // Single lane drives only the output pin, never while paused or deselected
        io_oe[`QSMPI_LANE_SO] <= act & read_active & ~pause_s;
        io_oe[`QSMPI_LANE_SI] <= act & read_active & quad_mode;
        io_oe[`QSMPI_LANE_WP] <= act & read_active & quad_mode;
        io_oe[`QSMPI_LANE_HOLD] <= act & read_active & quad_mode;
    end
end

endmodule

// [verif/qsmpi_pins_assertions.sv]
// Purpose: pin timing checks of the serial front end
// Assumes: sck phases last 4 ref cycles or more
// Notes: bound to qsmpi_pins below
`timescale 1ns/1ps
module qsmpi_pins_assertions
(
    input wire ref_clk,
    input wire sys_rst,
    input wire cs_n_pin,
    input wire sck_pin,
    input wire [3:0] io_i,
    input wire [3:0] io_o,
    input wire [3:0] io_oe,
    input wire quad_mode,
    input wire read_active,
    input wire selected_r,
    input wire standby_r,
    input wire paused_r,
    input wire sr_write_block_r
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    a_idle_stays_quiet: assert property (cs_n_pin [*5] |-> standby_r && io_oe == 4'h0) else $error("idle active");
    a_select_seen: assert property ((!cs_n_pin) [*4] |-> selected_r && !standby_r) else $error("no select");
    a_out_off_idle: assert property ((!quad_mode && !read_active) [*2] |-> io_oe == 4'h0) else $error("oe on");
    a_out_off_paused: assert property ((!quad_mode && paused_r) [*2] |-> !io_oe[1]) else $error("oe paused");
    a_out_on_fall: assert property (io_oe != 4'h0 && $changed(io_o) |-> !$past(sck_pin, 2)) else $error("out edge");
    a_protect_blocks: assert property ((!quad_mode && !io_i[2]) [*4] |-> sr_write_block_r) else $error("no block");
    a_protect_clears: assert property ((quad_mode || io_i[2]) [*4] |-> !sr_write_block_r) else $error("block");
    a_pause_freezes: assert property (paused_r [*2] |-> $stable(selected_r)) else $error("select moved");
    a_pause_seen: assert property ((!quad_mode && !io_i[3] && !cs_n_pin) [*4] |-> paused_r) else $error("no pause");
endmodule
bind qsmpi_pins qsmpi_pins_assertions qsmpi_pins_assertions_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .io_i(io_i), .io_o(io_o), .io_oe(io_oe), .quad_mode(quad_mode),
    .read_active(read_active), .selected_r(selected_r), .standby_r(standby_r), .paused_r(paused_r),
    .sr_write_block_r(sr_write_block_r));

// [verif/qsmpi_host.sv]
// Purpose: serial host model on the memory pins
// Assumes: half period 160 ns, unrelated to ref_clk
// Notes: released lanes toggle so stale data never looks valid
`timescale 1ns/1ps
module qsmpi_host
(
    output reg cs_n,
    output reg sck,
    output reg [3:0] lane,
    input wire [3:0] seen
);
    reg cpol = 1'b0;
    reg wp = 1'b1;
    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        lane = 4'hF;
    end
    task frame(input q, input rdir, input pz, input integer nb, input [31:0] wr, output [31:0] rd);
        integer k;
        begin
            rd = 32'h0;
            sck = cpol;
            cs_n = 1'b0;
            #200;
            for (k = (q ? nb * 2 : nb * 8) - 1; k >= 0; k = k - 1)
            begin
                sck = 1'b0;
                if (q)
                    lane = rdir ? ~lane : wr[k * 4 +: 4];
                else
                    lane = {1'b1, wp, ~lane[1], wr[k]};
                #160 sck = 1'b1;
                rd = q ? {rd[27:0], seen} : {rd[30:0], seen[1]};
                if (pz && k == 4)
                begin
                    #80 lane[3] = 1'b0;
                    #200;
                    repeat (4)
                    begin
                        #160 sck = ~sck;
                        cs_n = ~cs_n;
                    end
                    #200 lane[3] = 1'b1;
                end
                #160;
            end
            sck = cpol;
            #200 cs_n = 1'b1;
            // Pull-ups bring pause and spare lanes back high between frames
            lane = {1'b1, wp, 2'b11};
            #400;
        end
    endtask
endmodule

// [verif/tb_top.sv]
// Purpose: self-checking bench of qsmpi_pins
// Assumes: host model on the pins, core side driven here
// Notes: reads use mode 3, where the first fall loads
`timescale 1ns/1ps
module tb_top;
    reg ref_clk = 1'b0;
    reg sys_rst = 1'b1;
    reg quad_mode = 1'b0;
    reg read_active = 1'b0;
    reg rx_ready = 1'b1;
    reg tx_valid = 1'b0;
    reg [7:0] tx_data = 8'h00;
    reg chk = 1'b1;
    reg stall = 1'b0;
    wire cs_n, sck, rx_valid, tx_ready, sel, stby, pz, blk, ovr, und;
    wire [3:0] hl, io_o, io_oe;
    wire [3:0] io_i = (io_oe & io_o) | (~io_oe & hl);
    wire [7:0] rx_data;
    integer bad_count = 0;
    integer comparisons = 0;
    integer i, j;
    reg [31:0] rd, w;
    reg [7:0] expq [$];
    qsmpi_host qsmpi_host_inst (.cs_n(cs_n), .sck(sck), .lane(hl), .seen(io_i));
    qsmpi_pins qsmpi_pins_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .cs_n_pin(cs_n), .sck_pin(sck),
        .io_i(io_i), .io_o(io_o), .io_oe(io_oe), .quad_mode(quad_mode), .read_active(read_active),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .selected_r(sel), .standby_r(stby), .paused_r(pz), .sr_write_block_r(blk),
        .rx_overrun_r(ovr), .tx_underrun_r(und));
    initial forever #20 ref_clk = ~ref_clk;
    task check(input string nm, input logic [31:0] e, input logic [31:0] g);
        begin
            comparisons = comparisons + 1;
            if (g !== e)
            begin
                bad_count = bad_count + 1;
                $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task wrap_up;
        begin
            $display("mismatches %0d comparisons %0d", bad_count, comparisons);
            if (bad_count == 0 && comparisons > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // Random stalls on the core side; the buffer must absorb them
    always @(posedge ref_clk)
        #1 rx_ready = stall ? 1'b0 : ($urandom_range(3) != 0);
    always @(negedge ref_clk)
        if (rx_valid === 1'b1 && rx_ready && chk)
            check("rx_data", expq.pop_front(), rx_data);
    task wr_frame(input q, input p, input integer nb);
        begin
            w = $urandom;
            for (i = nb - 1; i >= 0; i = i - 1)
                expq.push_back(w[i * 8 +: 8]);
            @(posedge ref_clk) #1 quad_mode = q;
            qsmpi_host_inst.frame(q, 1'b0, p, nb, w, rd);
            repeat (24) @(posedge ref_clk);
            check("rx_left", 0, expq.size());
            check("wp_block", !q && !qsmpi_host_inst.wp, blk);
            check("standby", 1, stby);
        end
    endtask
    task rd_frame(input q, input give, input p);
        begin
            @(posedge ref_clk) #1 quad_mode = q;
            w = $urandom;
            tx_data = w[15:8];
            tx_valid = give;
            // Ready is looked at once settled; the take is the following edge
            while (give && tx_ready !== 1'b1)
            begin
                @(posedge ref_clk);
                #1;
            end
            @(posedge ref_clk);
            #1 tx_valid = 1'b0;
            read_active = 1'b1;
            // Single lane keeps sampling the input pin during a read
            if (!q)
                expq.push_back(w[7:0]);
            qsmpi_host_inst.cpol = 1'b1;
            qsmpi_host_inst.frame(q, 1'b1, p, 1, w, rd);
            @(posedge ref_clk) #1 read_active = 1'b0;
            check("rd_byte", give ? tx_data : 8'hFF, rd[7:0]);
        end
    endtask
    initial
    begin
        void'($urandom(99912));
        repeat (10) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        repeat (4) @(posedge ref_clk);
        for (j = 0; j < 12; j = j + 1)
        begin
            qsmpi_host_inst.cpol = j[0];
            qsmpi_host_inst.wp = $urandom;
            wr_frame(j[1], j == 5 || j == 8, 1 + j % 4);
            rd_frame(j[2], 1'b1, j == 9);
        end
        rd_frame(1'b0, 1'b0, 1'b0);
        check("underrun", 1, und);
        repeat (8) @(posedge ref_clk);
        check("rx_left", 0, expq.size());
        stall = 1'b1;
        chk = 1'b0;
        qsmpi_host_inst.frame(1'b0, 1'b0, 1'b0, 4, $urandom, rd);
        check("overrun", 1, ovr);
        stall = 1'b0;
        repeat (20) @(posedge ref_clk);
        check("rx_drained", 0, rx_valid);
        wrap_up;
    end
    initial
    begin
        #1000000;
        bad_count = bad_count + 1;
        wrap_up;
    end
endmodule
